// >>> src/supervisor_pkg.sv
// Shared constants and types for the supply supervisor and watchdog
package supervisor_pkg;

  // ----------------------------------------------------------------
  // Clock and timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_PERIOD_PS = 4000;
  localparam int unsigned TICK_PERIOD_NS  = 1000;
  localparam int unsigned TICK_CYCLES     = (TICK_PERIOD_NS * 1000) / CLOCK_PERIOD_PS;
  localparam int unsigned TICK_CNT_W      = 8;

  // Reset hold time, counted in timebase ticks
  localparam int unsigned RESET_HOLD_MS    = 50;
  localparam int unsigned RESET_HOLD_TICKS = (RESET_HOLD_MS * 1000000) / TICK_PERIOD_NS;

  // Watchdog timeout default in ticks (plain value, software may change it)
  localparam int unsigned WDOG_TIMEOUT_TICKS = 100000;
  localparam int unsigned TICKS_W            = 24;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_TIMEOUT    = 8'h04;
  localparam logic [7:0] ADDR_STATE      = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;

  localparam int unsigned CTRL_WDOG_EN_BIT = 0;
  localparam logic        CTRL_RESET       = 1'h1;
  localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;

  // Interrupt event bit positions
  localparam int unsigned EV_SUPPLY_LOW = 0;
  localparam int unsigned EV_WDOG       = 1;
  localparam int unsigned EV_POWER_FAIL = 2;
  localparam int unsigned EV_BACKUP     = 3;
  localparam int unsigned EV_W          = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Pin-side inputs, all asynchronous to clock
  typedef struct packed {
    logic supply_low;        // Supply sense below threshold
    logic power_fail_low;    // Power-fail sense below reference
    logic main_below_backup; // Main supply under backup cell
    logic kick_level;        // Kick input logic level
    logic kick_mid;          // Kick input floating or mid-supply
    logic chip_select_in_n;  // Incoming memory chip select
  } pins_t;

  typedef enum logic [1:0] {
    ST_SUPPLY_LOW,
    ST_HOLD,
    ST_RUN
  } reset_state_t;

endpackage

// >>> src/supply_supervisor_watchdog.sv
// Supply supervisor with reset hold, watchdog, power-fail and backup select
`timescale 1ns/10ps
module supply_supervisor_watchdog
  import supervisor_pkg::*;
#(
  parameter logic [TICKS_W-1:0] HOLD_TICKS   = TICKS_W'(RESET_HOLD_TICKS),
  parameter logic [TICKS_W-1:0] WDOG_DEFAULT = TICKS_W'(WDOG_TIMEOUT_TICKS),
  parameter logic [TICK_CNT_W-1:0] TICK_DIV  = TICK_CNT_W'(TICK_CYCLES)
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Comparator results and pins
  input  wire logic        supply_sense_input,
  input  wire logic        power_fail_sense,
  input  wire logic        backup_cell_input,
  input  wire logic        watchdog_kick_input,
  input  wire logic        kick_mid_level,
  input  wire logic        chip_select_in_n,
  // Outputs
  output logic             reset_n,
  output logic             reset,
  output logic             supply_low_flag_n,
  output logic             watchdog_timeout_flag_n,
  output logic             power_fail_flag_n,
  output logic             backup_active_flag,
  output logic             chip_select_out_n,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  pins_t raw;
  pins_t sync_a;
  pins_t pin;

  assign raw = '{supply_low:        supply_sense_input,
                 power_fail_low:    power_fail_sense,
                 main_below_backup: backup_cell_input,
                 kick_level:        watchdog_kick_input,
                 kick_mid:          kick_mid_level,
                 chip_select_in_n:  chip_select_in_n};

  // Two flops per pin; first stage feeds only the second
  // Reset values mean supply ok, kick floating and chip select idle,
  // so no false event or kick edge follows the release of reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= '{default: 1'b0, chip_select_in_n: 1'b1, kick_mid: 1'b1};
      pin    <= '{default: 1'b0, chip_select_in_n: 1'b1, kick_mid: 1'b1};
    end else begin
      sync_a <= raw;
      pin    <= sync_a;
    end
  end

  // ----------------------------------------------------------------
  // Timebase tick divider
  // ----------------------------------------------------------------
  logic [TICK_CNT_W-1:0] tick_cnt;
  logic                  tick;
  wire                   tick_wrap = (tick_cnt == TICK_DIV - TICK_CNT_W'(1));

  // Timebase is an enable, not a second clock, so nothing crosses domains
  // One-cycle enable per tick period
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? '0 : tick_cnt + TICK_CNT_W'(1);
      tick     <= tick_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  logic               wdog_enable;
  logic [TICKS_W-1:0] wdog_timeout;
  logic [EV_W-1:0]    irq_status;
  logic [EV_W-1:0]    irq_mask;

  // Address decode; one strobe per register
  wire apb_access = psel && penable && pready;
  wire apb_write  = apb_access && pwrite;
  wire hit_ctrl   = (paddr == ADDR_CONTROL);
  wire hit_tmo    = (paddr == ADDR_TIMEOUT);
  wire hit_state  = (paddr == ADDR_STATE);
  wire hit_irqs   = (paddr == ADDR_IRQ_STATUS);
  wire hit_mask   = (paddr == ADDR_IRQ_MASK);
  wire hit_any    = hit_ctrl | hit_tmo | hit_state | hit_irqs | hit_mask;

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  reset_state_t       state;
  reset_state_t       next_state;
  logic [TICKS_W-1:0] hold_cnt;
  logic [TICKS_W-1:0] wdog_cnt;
  logic               kick_prev;

  // Kick edge and terminal counts; a timeout fires only in RUN,
  // so a reset pulse can never stretch itself
  wire kick_edge  = (pin.kick_level != kick_prev);
  wire wdog_armed = wdog_enable && !pin.kick_mid;
  wire hold_done  = tick && (hold_cnt >= HOLD_TICKS - TICKS_W'(1));
  wire wdog_fire  = (state == ST_RUN) && wdog_armed && !kick_edge
                    && tick && (wdog_cnt >= wdog_timeout - TICKS_W'(1));

  // Next state of the reset sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_SUPPLY_LOW: if (!pin.supply_low) next_state = ST_HOLD;
      ST_HOLD: begin
        if (pin.supply_low)  next_state = ST_SUPPLY_LOW;
        else if (hold_done) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (pin.supply_low)  next_state = ST_SUPPLY_LOW;
        else if (wdog_fire) next_state = ST_HOLD;
      end
      // Unused code falls back to the safe, reset-asserting state
      default: next_state = ST_SUPPLY_LOW;
    endcase
  end

  wire next_reset_active = (next_state != ST_RUN);

  // State and hold counter; hold restarts on every entry to ST_HOLD
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state    <= ST_SUPPLY_LOW;
      hold_cnt <= '0;
    end else begin
      state <= next_state;
      if (state != ST_HOLD) hold_cnt <= '0;
      else if (tick)        hold_cnt <= hold_cnt + TICKS_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------
  // Held clear outside ST_RUN so the host gets a full period after reset
  // Clearing on fire means a second timeout needs a whole new period
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      kick_prev <= 1'b0;
      wdog_cnt  <= '0;
    end else begin
      kick_prev <= pin.kick_level;
      if (state != ST_RUN || !wdog_armed || kick_edge || wdog_fire)
        wdog_cnt <= '0;
      else if (tick)
        wdog_cnt <= wdog_cnt + TICKS_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  // Reset pair from the next state, so both outputs move on one edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reset_n <= 1'b0;
      reset   <= 1'b1;
    end else begin
      reset_n <= !next_reset_active;
      reset   <= next_reset_active;
    end
  end

  // Level flags, one flop after the synchroniser
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      supply_low_flag_n <= 1'b0;
      power_fail_flag_n <= 1'b0;
    end else begin
      supply_low_flag_n <= !pin.supply_low;
      power_fail_flag_n <= !(pin.power_fail_low
                             || pin.main_below_backup);
    end
  end

  // Chip select gate; registered, so it lags the pin by three cycles
  // instead of the fast path a bare gate would give
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      chip_select_out_n <= 1'b1;
    end else begin
      chip_select_out_n <= pin.supply_low | pin.chip_select_in_n;
    end
  end

  // Timeout flag: set low on fire, high on kick edge or low supply
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_timeout_flag_n <= 1'b1;
    end else if (pin.supply_low) begin
      watchdog_timeout_flag_n <= 1'b1;
    end else if (wdog_fire) begin
      watchdog_timeout_flag_n <= 1'b0;
    end else if (kick_edge) begin
      watchdog_timeout_flag_n <= 1'b1;
    end
  end

  // Supply source; mixed comparator results hold the last choice
  // While both comparators agree, one glitching alone can never flip the source
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      backup_active_flag <= 1'b0;
    end else if (!pin.main_below_backup && !pin.supply_low) begin
      backup_active_flag <= 1'b0;
    end else if (pin.main_below_backup && pin.supply_low) begin
      backup_active_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  logic            pf_prev;
  logic            bk_prev;
  logic            sl_prev;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] w1c;
  logic [EV_W-1:0] next_status;

  assign events[EV_SUPPLY_LOW] = pin.supply_low && !sl_prev;
  assign events[EV_WDOG]       = wdog_fire;
  assign events[EV_POWER_FAIL] = !power_fail_flag_n && pf_prev;
  assign events[EV_BACKUP]     = backup_active_flag != bk_prev;
  assign w1c = (apb_write && hit_irqs) ? pwdata[EV_W-1:0] : '0;
  assign next_status = (irq_status & ~w1c) | events;

  // Delayed copies for edge detection; reset so no false edge follows
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sl_prev <= 1'b0;
      pf_prev <= 1'b0;
      bk_prev <= 1'b0;
    end else begin
      sl_prev <= pin.supply_low;
      pf_prev <= power_fail_flag_n;
      bk_prev <= backup_active_flag;
    end
  end

  // Sticky status; a new event wins over a same-cycle clear, so an
  // event landing on the clearing write is never lost
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq        <= |(next_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, registered answer
  // ----------------------------------------------------------------
  logic [31:0] read_mux;
  logic [31:0] ctrl_word;
  logic [31:0] tmo_word;
  logic [31:0] state_word;
  logic [31:0] irqs_word;
  logic [31:0] mask_word;

  // Register images; fields sit in the low bits, the rest read zero
  assign ctrl_word  = 32'(wdog_enable) << CTRL_WDOG_EN_BIT;
  assign tmo_word   = 32'(wdog_timeout);
  assign state_word = {24'h00_0000, 1'b0, pin.kick_mid, backup_active_flag,
                       !watchdog_timeout_flag_n, !power_fail_flag_n,
                       !supply_low_flag_n, state == ST_HOLD, !reset_n};
  assign irqs_word  = 32'(irq_status);
  assign mask_word  = 32'(irq_mask);

  // Read data selection; unmapped reads return zero
  assign read_mux = hit_ctrl  ? ctrl_word  :
                    hit_tmo   ? tmo_word   :
                    hit_state ? state_word :
                    hit_irqs  ? irqs_word  :
                    hit_mask  ? mask_word  : 32'h0000_0000;

  // Ready rises in the second access cycle; data and error with it
  // Fixed latency keeps the slave small; back-to-back setups still work
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? read_mux : 32'h0000_0000;
      pslverr <= psel && penable && !pready && !hit_any;
    end
  end

  // Software-written registers take effect at the completing edge
  // A zero timeout is refused: its terminal count would wrap to the largest value
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wdog_enable  <= CTRL_RESET;
      wdog_timeout <= WDOG_DEFAULT;
      irq_mask     <= IRQ_MASK_RESET;
    end else if (apb_write) begin
      if (hit_ctrl) wdog_enable <= pwdata[CTRL_WDOG_EN_BIT];
      if (hit_tmo && pwdata[TICKS_W-1:0] != '0) wdog_timeout <= pwdata[TICKS_W-1:0];
      if (hit_mask) irq_mask <= pwdata[EV_W-1:0];
    end
  end

endmodule // supply_supervisor_watchdog

// >>> verif/supervisor_chk.sv
// Concurrent checks on the supervisor's pin behaviour
`timescale 1ns/10ps
module supervisor_chk #(
  parameter int HOLD_TICKS = 4,
  parameter int TICK_DIV   = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic supply_sense_input,
  input wire logic power_fail_sense,
  input wire logic backup_cell_input,
  input wire logic watchdog_kick_input,
  input wire logic kick_mid_level,
  input wire logic chip_select_in_n,
  input wire logic reset_n,
  input wire logic reset,
  input wire logic supply_low_flag_n,
  input wire logic watchdog_timeout_flag_n,
  input wire logic power_fail_flag_n,
  input wire logic backup_active_flag,
  input wire logic chip_select_out_n
);
  logic [15:0] ok_cnt;
  logic [15:0] low_cnt;

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Saturating counts of supply-ok time and reset-held time
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ok_cnt  <= 16'h0000;
      low_cnt <= 16'h0000;
    end else begin
      ok_cnt  <= supply_sense_input ? 16'h0000 : ok_cnt + 16'(ok_cnt != 16'hFFFF);
      low_cnt <= reset_n ? 16'h0000 : low_cnt + 16'(low_cnt != 16'hFFFF);
    end
  end

  // ----------------------------------------------------------------
  // Pin relations, three edges of synchroniser latency allowed
  // ----------------------------------------------------------------
  AST_INV: assert property (reset == !reset_n)
    else $error("reset is not the inverse of reset_n");
  AST_LOW: assert property (supply_sense_input [*3]
    |=> !reset_n && !supply_low_flag_n) else $error("supply low did not force reset");
  AST_UP: assert property (!supply_sense_input [*3] |=> supply_low_flag_n)
    else $error("supply flag stuck low");
  AST_HOLD: assert property ($rose(reset_n) |-> ok_cnt >= HOLD_TICKS * TICK_DIV)
    else $error("reset released too early after supply recovery");
  // Watchdog pulse may lose up to one tick to phase
  AST_PULSE: assert property ($rose(reset_n) |-> low_cnt >= (HOLD_TICKS - 1) * TICK_DIV
    && (ok_cnt <= low_cnt + 4 || low_cnt <= (HOLD_TICKS + 1) * TICK_DIV + 4))
    else $error("watchdog reset pulse width wrong");
  AST_WDO: assert property ($fell(watchdog_timeout_flag_n) |-> $fell(reset_n))
    else $error("timeout flag fell without reset");
  AST_MID: assert property (kick_mid_level [*4] |-> !$fell(watchdog_timeout_flag_n))
    else $error("timeout while kick floating");
  AST_CLR: assert property (!watchdog_timeout_flag_n && !kick_mid_level
    && $changed(watchdog_kick_input) |-> ##[1:4] watchdog_timeout_flag_n)
    else $error("kick edge did not clear timeout flag");
  AST_LL: assert property (!supply_low_flag_n && !$past(supply_low_flag_n)
    |-> watchdog_timeout_flag_n) else $error("timeout flag low during supply low");
  AST_CS_OFF: assert property (supply_sense_input [*3] |=> chip_select_out_n)
    else $error("chip select not blocked");
  AST_CS_ON: assert property ((!supply_sense_input && $stable(chip_select_in_n)) [*3]
    |=> chip_select_out_n == $past(chip_select_in_n)) else $error("chip select not passed");
  AST_PF: assert property ($stable(power_fail_sense || backup_cell_input) [*3]
    |=> power_fail_flag_n == !$past(power_fail_sense || backup_cell_input))
    else $error("power-fail flag wrong");
  AST_BAK: assert property ((backup_cell_input == supply_sense_input) [*3]
    |=> backup_active_flag == $past(supply_sense_input, 3)) else $error("supply select wrong");
  AST_KEEP: assert property ((backup_cell_input != supply_sense_input) [*4]
    |-> $stable(backup_active_flag)) else $error("supply select changed on mixed input");
endmodule // supervisor_chk

// >>> verif/host_kicker.sv
// Host model that services the watchdog kick input
`timescale 1ns/10ps
module host_kicker (
  input  wire logic       clock,
  input  wire logic       kick_en,
  input  wire logic [3:0] gap,
  output logic            kick
);
  logic [3:0] cnt    = 4'h0;
  logic       toggle = 1'b0;

  assign kick = toggle;
  // Toggle every gap+1 cycles; disabled, the level stands still and starves the timer
  always @(posedge clock) begin
    cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
    if (kick_en && cnt >= gap) toggle <= !toggle;
  end
endmodule // host_kicker

// >>> verif/tb.sv
// Self-checking testbench for the supply supervisor and watchdog
`timescale 1ns/10ps
module tb;
  import supervisor_pkg::*;
  localparam int HOLD = 4;
  localparam int DIV  = 2;
  logic        clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        kick_en = 1'b1;
  logic [3:0]  gap = 4'h2;
  pins_t       pins = 6'h01;
  pins_t       p;
  logic        pready, pslverr, reset_n, reset, irq, watchdog_kick_input, bk;
  logic        supply_low_flag_n, watchdog_timeout_flag_n, power_fail_flag_n;
  logic        backup_active_flag, chip_select_out_n;
  logic [31:0] prdata;
  logic [32:0] expq[$];
  int          fails = 0, n_checks = 0, cyc = 0, n, seed;

  // ----------------------------------------------------------------
  // Clock, design and host model
  // ----------------------------------------------------------------
  always #2 clock = ~clock;
  // Short hold, timeout and tick keep the run brief
  supply_supervisor_watchdog #(.HOLD_TICKS(24'(HOLD)), .WDOG_DEFAULT(24'h8), .TICK_DIV(8'(DIV)))
    i_dut (.*, .supply_sense_input(pins.supply_low), .power_fail_sense(pins.power_fail_low),
    .backup_cell_input(pins.main_below_backup), .kick_mid_level(pins.kick_mid),
    .chip_select_in_n(pins.chip_select_in_n));
  host_kicker i_host (.clock(clock), .kick_en(kick_en), .gap(gap), .kick(watchdog_kick_input));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; reads leave their expected word in the queue
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expq.push_back(x);
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 200) begin
      @(posedge clock);
      n++;
    end
  endtask

  // Read-data monitor and hang guard
  always @(posedge clock) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, expq.pop_front());
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h61BC;
    repeat (4) @(posedge clock);
    #1;
    chk({reset_n, reset, watchdog_timeout_flag_n, chip_select_out_n, irq}, 5'b01110);
    @(posedge clock);
    arst_n <= 1'b1;
    apb(1'b0, ADDR_CONTROL, 32'h0, 33'h1);
    apb(1'b0, ADDR_IRQ_MASK, 32'h0, 33'h0);
    apb(1'b0, ADDR_TIMEOUT, 32'h0, 33'h8);
    apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
    wait_for(reset_n, 1'b1);
    repeat (60) @(posedge clock);
    #1;
    chk({reset_n, watchdog_timeout_flag_n}, 2'b11);
    @(posedge clock);
    // A zero timeout write is refused; the old value reads back
    apb(1'b1, ADDR_TIMEOUT, 32'h0, 33'h0);
    apb(1'b0, ADDR_TIMEOUT, 32'h0, 33'h8);
    apb(1'b1, ADDR_IRQ_MASK, 32'h2, 33'h0);
    kick_en <= 1'b0;
    wait_for(watchdog_timeout_flag_n, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    chk({reset_n, reset, irq}, 3'b011);
    @(posedge clock);
    kick_en <= 1'b1;
    apb(1'b1, ADDR_IRQ_MASK, 32'h0, 33'h0);
    repeat (4) @(posedge clock);
    #1;
    chk({irq, watchdog_timeout_flag_n}, 2'b01);
    @(posedge clock);
    apb(1'b1, ADDR_IRQ_STATUS, 32'hF, 33'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h2, 33'h0);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0, 33'h0);
    pins.kick_mid <= 1'b1;
    kick_en <= 1'b0;
    repeat (80) @(posedge clock);
    #1;
    chk({reset_n, watchdog_timeout_flag_n, irq}, 3'b110);
    @(posedge clock);
    apb(1'b0, ADDR_STATE, 32'h0, 33'h40);
    pins.kick_mid <= 1'b0;
    kick_en <= 1'b1;
    gap <= 4'h6;
    bk = 1'b0;
    // Random pin mixes, each held past the synchroniser latency
    for (int i = 0; i < 24; i++) begin
      @(posedge clock);
      p = 6'($random(seed));
      pins <= p;
      repeat (5) @(posedge clock);
      #1;
      if (p.main_below_backup == p.supply_low) bk = p.supply_low;
      chk(supply_low_flag_n, !p.supply_low);
      chk(power_fail_flag_n, !(p.power_fail_low || p.main_below_backup));
      chk(chip_select_out_n, p.supply_low || p.chip_select_in_n);
      chk(backup_active_flag, bk);
      if (p.supply_low) chk({reset_n, watchdog_timeout_flag_n}, 2'b01);
    end
    summarize();
  end
endmodule // tb

bind supply_supervisor_watchdog supervisor_chk #(.HOLD_TICKS(HOLD_TICKS), .TICK_DIV(TICK_DIV))
  i_chk (.*);
